// ===== gacs_top.sv
// Gain adjust registers plus output data clock hold and realignment logic.
// Assumes resync and the sampling clock enables arrive synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module gacs_top (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wrEn,
    input wire logic [3:0] wrAddr,
    input wire logic [15:0] wrData,
    input wire logic sampleRise,
    input wire logic sampleFall,
    input wire logic outputClockResync,
    input wire logic ddrEnable,
    input wire logic outputEdgeSelectPin,
    input wire logic outputEdgeBit,
    input wire logic extendedMode,
    input wire logic calibrationRunning,
    output logic dataOutputClock,
    output logic dataLaunchEdge,
    output logic outClockHeld,
    output logic resyncDuringCal,
    output logic [8:0] gainAdjust,
    output logic [7:0] offsetMag,
    output logic offsetNeg,
    output logic gainInWindow
);
    gacs_pkg::gacs_state_e state_q, state_d;
    logic [3:0] div_q, div_d;
    logic [3:0] delay_q, delay_d;
    logic clk_q, clk_d;
    logic launch_q;
    logic calFlag_q;
    logic [3:0] riseCount_q;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    gacs_gain_reg u_regs (
        .clk(clk),
        .rstn(rstn),
        .wrEn(wrEn),
        .wrAddr(wrAddr),
        .wrData(wrData),
        .gainAdjust(gainAdjust),
        .offsetMag(offsetMag),
        .offsetNeg(offsetNeg),
        .gainInWindow(gainInWindow)
    );

    // Edge setting: register bit in extended mode, else pin
    wire logic edgeSel = extendedMode ? outputEdgeBit : outputEdgeSelectPin;
    // Hold level per rate and edge; shared by the sequencer and its checks
    function automatic logic hold_level_f(input logic ddr, input logic edgeRise);
        // DDR parks low; SDR parks opposite its launch edge
        return ddr ? 1'b0 : ~edgeRise;
    endfunction

    // Hold level: DDR idles low, SDR idles opposite its launch edge
    wire logic holdLevel = hold_level_f(ddrEnable, edgeSel);
    wire logic divWrap = (div_q == gacs_pkg::SAMPLE_DIV_LAST);

    // ------------------------------------------------------------
    // Resync sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        div_d = div_q;
        delay_d = delay_q;
        clk_d = clk_q;
        case (state_q)
            gacs_pkg::GACS_RUN: begin
                if (sampleRise) begin
                    div_d = divWrap ? 4'h0 : div_q + 4'h1;
                    if (divWrap) begin
                        clk_d = ~clk_q;
                    end
                end
            end
            gacs_pkg::GACS_HOLD: begin
                if (!outputClockResync && sampleRise) begin
                    state_d = gacs_pkg::GACS_ALIGN;
                end
            end
            gacs_pkg::GACS_ALIGN: begin
                if (sampleFall) begin
                    div_d = 4'h0;
                    delay_d = gacs_pkg::SD_CYCLES;
                    state_d = gacs_pkg::GACS_WAIT;
                end
            end
            gacs_pkg::GACS_WAIT: begin
                if (sampleRise) begin
                    delay_d = delay_q - 4'h1;
                    if (delay_q == 4'h1) begin
                        state_d = gacs_pkg::GACS_RUN;
                    end
                end
            end
            default: state_d = gacs_pkg::GACS_HOLD;
        endcase
        // Async entry at any state; may truncate a high phase
        if (outputClockResync) begin
            state_d = gacs_pkg::GACS_HOLD;
        end
        if (state_d != gacs_pkg::GACS_RUN) begin
            clk_d = holdLevel;
        end
    end

    // State update, kept short
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_q <= gacs_pkg::GACS_RUN;
            div_q <= 4'h0;
            delay_q <= 4'h0;
            clk_q <= 1'b0;
        end else begin
            state_q <= state_d;
            div_q <= div_d;
            delay_q <= delay_d;
            clk_q <= clk_d;
        end
    end

    // Launch edge flag and sticky calibration misuse flag
    always_ff @(posedge clk) begin
        if (!rstn) begin
            launch_q <= 1'b0;
            calFlag_q <= 1'b0;
        end else begin
            launch_q <= ddrEnable | edgeSel;
            calFlag_q <= calFlag_q | (outputClockResync & calibrationRunning);
        end
    end

    assign dataOutputClock = clk_q;
    assign dataLaunchEdge = launch_q;
    assign outClockHeld = (state_q != gacs_pkg::GACS_RUN);
    assign resyncDuringCal = calFlag_q;

    // ------------------------------------------------------------
    // Check helpers
    // ------------------------------------------------------------
    // Sampling rises seen in WAIT since the aligning fall; saturates, never wraps
    always_ff @(posedge clk) begin
        if (!rstn) begin
            riseCount_q <= 4'h0;
        end else if (state_q == gacs_pkg::GACS_ALIGN) begin
            riseCount_q <= 4'h0;
        end else if (state_q == gacs_pkg::GACS_WAIT && sampleRise && riseCount_q != 4'hF) begin
            riseCount_q <= riseCount_q + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Hold entry and hold level
    hold_level_a: assert property (@(posedge clk) disable iff (!rstn)
        outputClockResync ##1 outputClockResync |=> dataOutputClock == $past(holdLevel))
        else $error("clock not at hold level");
    held_level_a: assert property (@(posedge clk) disable iff (!rstn)
        outClockHeld |-> dataOutputClock == $past(hold_level_f(ddrEnable, edgeSel)))
        else $error("held clock off its level");
    hold_entry_a: assert property (@(posedge clk) disable iff (!rstn)
        outputClockResync |=> outClockHeld)
        else $error("resync not obeyed");

    // Release, alignment and resume
    release_a: assert property (@(posedge clk) disable iff (!rstn)
        state_q == gacs_pkg::GACS_HOLD && !outputClockResync && !sampleRise |=> state_q != gacs_pkg::GACS_ALIGN)
        else $error("release off rising edge");
    align_div_a: assert property (@(posedge clk) disable iff (!rstn)
        state_q == gacs_pkg::GACS_ALIGN && sampleFall && !outputClockResync |=> div_q == 4'h0)
        else $error("divider not aligned");
    align_wait_a: assert property (@(posedge clk) disable iff (!rstn)
        state_q == gacs_pkg::GACS_ALIGN && !sampleFall && !outputClockResync |=> state_q == gacs_pkg::GACS_ALIGN)
        else $error("aligned off the falling edge");
    wait_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        state_q == gacs_pkg::GACS_WAIT && !sampleRise && !outputClockResync
        |=> state_q == gacs_pkg::GACS_WAIT && $stable(delay_q))
        else $error("wait count moved off a rise");
    resume_a: assert property (@(posedge clk) disable iff (!rstn)
        state_q == gacs_pkg::GACS_WAIT && delay_q == 4'h1 && sampleRise && !outputClockResync
        |=> !outClockHeld)
        else $error("clock did not resume");
    latency_a: assert property (@(posedge clk) disable iff (!rstn)
        outClockHeld ##1 !outClockHeld |-> riseCount_q == gacs_pkg::SD_CYCLES)
        else $error("resume latency wrong");

    // Free running output clock
    run_free_a: assert property (@(posedge clk) disable iff (!rstn)
        !outClockHeld && !sampleRise && !outputClockResync |=> $stable(dataOutputClock))
        else $error("clock moved off a rise");
    run_toggle_a: assert property (@(posedge clk) disable iff (!rstn)
        !outClockHeld && sampleRise && divWrap && !outputClockResync |=> dataOutputClock != $past(dataOutputClock))
        else $error("clock missed its toggle");

    // Launch edge and calibration misuse flag
    edge_a: assert property (@(posedge clk) disable iff (!rstn)
        !ddrEnable ##1 1'b1 |-> dataLaunchEdge == $past(edgeSel))
        else $error("launch edge wrong");
    ddr_launch_a: assert property (@(posedge clk) disable iff (!rstn)
        ddrEnable ##1 1'b1 |-> dataLaunchEdge)
        else $error("DDR launch flag low");
    cal_flag_a: assert property (@(posedge clk) disable iff (!rstn)
        outputClockResync && calibrationRunning |=> resyncDuringCal)
        else $error("cal misuse not flagged");
    cal_sticky_a: assert property (@(posedge clk) disable iff (!rstn)
        resyncDuringCal |=> resyncDuringCal)
        else $error("cal misuse flag dropped");

    // Main scenarios
    resync_c: cover property (@(posedge clk) disable iff (!rstn) outputClockResync ##1 !outputClockResync);
    resume_c: cover property (@(posedge clk) disable iff (!rstn) outClockHeld ##1 !outClockHeld);
    ddr_c: cover property (@(posedge clk) disable iff (!rstn) ddrEnable && outClockHeld);
    sdr_c: cover property (@(posedge clk) disable iff (!rstn) !ddrEnable && outClockHeld);
endmodule
`default_nettype wire

// ===== gacs_pkg.sv
// Constants and register layout for the gain adjust and output clock resync block.
// Assumes a single 25 MHz clock; the sampling clock is modelled as a clock-enable.
// How it works
// - New gain applies without recalibration
// - Plus zero and minus zero offsets differ
// - Resync accepted at any moment
// - Hold level set by rate and edge
// - Hold entry may cut a runt pulse
// - Align divider at next falling edge
// - Resume after normal sample-to-clock delay
// - SDR edge bit picks data transition edge
package gacs_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] GAIN_ADDR = 4'h3;
    localparam logic [3:0] OFFSET_ADDR = 4'h2;
    localparam logic [15:0] GAIN_RESET = 16'h807F;
    localparam logic [15:0] OFFSET_RESET = 16'h007F;
    localparam int GAIN_MSB = 15;
    localparam int GAIN_LSB = 7;
    localparam int OFFSET_MSB = 15;
    localparam int OFFSET_LSB = 8;
    localparam int OFFSET_SIGN = 7;
    localparam logic [6:0] LOW_ONES = 7'h7F;
    localparam logic [8:0] GAIN_WIN_LO = 9'h0C0;
    localparam logic [8:0] GAIN_WIN_HI = 9'h1C0;
    // ------------------------------------------------------------
    // Timing, in sampling-clock periods
    // ------------------------------------------------------------
    localparam int SAMPLE_TO_OUTCLOCK_DELAY = 4;
    localparam logic [3:0] SD_CYCLES = 4'(SAMPLE_TO_OUTCLOCK_DELAY);
    localparam int SAMPLE_DIV = 2;
    localparam logic [3:0] SAMPLE_DIV_LAST = 4'(SAMPLE_DIV - 1);
    typedef enum logic [1:0] {GACS_RUN, GACS_HOLD, GACS_ALIGN, GACS_WAIT} gacs_state_e;
endpackage

// ===== gacs_gain_reg.sv
// Write-only gain adjust and offset registers of the serial control port.
// Assumes the serial port delivers a one-cycle write strobe with address and data.
`timescale 1ns/1ps
`default_nettype none
module gacs_gain_reg (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wrEn,
    input wire logic [3:0] wrAddr,
    input wire logic [15:0] wrData,
    output logic [8:0] gainAdjust,
    output logic [7:0] offsetMag,
    output logic offsetNeg,
    output logic gainInWindow
);
    logic [15:0] gain_q;
    logic [15:0] offset_q;
    wire logic gainHit = wrEn && (wrAddr == gacs_pkg::GAIN_ADDR);
    wire logic offsetHit = wrEn && (wrAddr == gacs_pkg::OFFSET_ADDR);

    // ------------------------------------------------------------
    // Storage; low bits forced to ones whatever is written
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            gain_q <= gacs_pkg::GAIN_RESET;
            offset_q <= gacs_pkg::OFFSET_RESET;
        end else begin
            if (gainHit) begin
                gain_q <= {wrData[15:7], gacs_pkg::LOW_ONES};
            end
            if (offsetHit) begin
                offset_q <= {wrData[15:7], gacs_pkg::LOW_ONES};
            end
        end
    end

    // Field decode; sign kept separate so +0 and -0 stay distinct
    assign gainAdjust = gain_q[gacs_pkg::GAIN_MSB:gacs_pkg::GAIN_LSB];
    assign offsetMag = offset_q[gacs_pkg::OFFSET_MSB:gacs_pkg::OFFSET_LSB];
    assign offsetNeg = offset_q[gacs_pkg::OFFSET_SIGN];
    // Advisory only: software owns the window
    assign gainInWindow = (gainAdjust >= gacs_pkg::GAIN_WIN_LO) && (gainAdjust <= gacs_pkg::GAIN_WIN_HI);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    gain_update_a: assert property (@(posedge clk) disable iff (!rstn)
        gainHit |=> gainAdjust == $past(wrData[15:7]))
        else $error("gain not applied after write");
    gain_low_a: assert property (@(posedge clk) disable iff (!rstn)
        gain_q[6:0] == gacs_pkg::LOW_ONES)
        else $error("gain low bits not ones");
    sign_kept_a: assert property (@(posedge clk) disable iff (!rstn)
        offsetHit |=> offsetNeg == $past(wrData[7]))
        else $error("offset sign lost");
    gain_write_c: cover property (@(posedge clk) disable iff (!rstn) gainHit);
endmodule
`default_nettype wire

// ===== gacs_far_model.sv
// Far side model: sampling clock edge pulses and the resync source.
// Assumes clk is the bench clock; everything here changes 1 ns after its rising edge.
`timescale 1ns/1ps
`default_nettype none
module gacs_far_model (
    input wire logic clk,
    input wire logic resyncReq,
    input wire logic calibrationRunning,
    input wire logic calOverride,
    output logic sampleRise,
    output logic sampleFall,
    output logic outputClockResync
);
    logic [1:0] phase = 2'h0;
    logic req = 1'b0;
    logic calBusy = 1'b0;
    logic calForce = 1'b0;
    // ------------------------------------------------------------
    // Sampling period of four clk cycles; resync released only on a rise
    // ------------------------------------------------------------
    initial begin
        sampleRise = 1'b0;
        sampleFall = 1'b0;
        outputClockResync = 1'b0;
    end
    always @(posedge clk) begin
        // Bench inputs taken at the edge, so its own 1 ns changes never race this block
        req = resyncReq;
        calBusy = calibrationRunning;
        calForce = calOverride;
        #1;
        phase = phase + 2'h1;
        sampleRise = (phase == 2'h0);
        sampleFall = (phase == 2'h2);
        // Override exists only so a scenario can break the calibration guard
        if (req && (!calBusy || calForce)) begin
            outputClockResync = 1'b1;
        end else if (!req && sampleRise) begin
            outputClockResync = 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the gain registers and output clock resync logic.
// Assumes the far side model supplies sampling edges and the resync line.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic wrEn = 1'b0;
    logic [3:0] wrAddr = 4'h0;
    logic [15:0] wrData = 16'h0000;
    logic ddrEnable = 1'b0, outputEdgeSelectPin = 1'b0, outputEdgeBit = 1'b0, extendedMode = 1'b0;
    logic calibrationRunning = 1'b0, resyncReq = 1'b0, calOverride = 1'b0, es = 1'b0;
    logic sampleRise, sampleFall, outputClockResync, dataOutputClock, dataLaunchEdge;
    logic outClockHeld, resyncDuringCal, offsetNeg, gainInWindow;
    logic [8:0] gainAdjust, v;
    logic [7:0] offsetMag;
    logic [31:0] expQ[$];
    int num_errors = 0, check_count = 0, cyc = 0, n, fs, rl;
    wire logic [22:0] outs = {resyncDuringCal, dataLaunchEdge, outClockHeld, dataOutputClock,
        offsetNeg, offsetMag, gainInWindow, gainAdjust};
    logic [8:0] gTab[5] = '{9'h0BF, 9'h0C0, 9'h1C0, 9'h1C1, 9'h1FF};

    gacs_top gacs_top_i (.clk(clk), .rstn(rstn), .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData),
        .sampleRise(sampleRise), .sampleFall(sampleFall), .outputClockResync(outputClockResync),
        .ddrEnable(ddrEnable), .outputEdgeSelectPin(outputEdgeSelectPin), .outputEdgeBit(outputEdgeBit),
        .extendedMode(extendedMode), .calibrationRunning(calibrationRunning),
        .dataOutputClock(dataOutputClock), .dataLaunchEdge(dataLaunchEdge), .outClockHeld(outClockHeld),
        .resyncDuringCal(resyncDuringCal), .gainAdjust(gainAdjust), .offsetMag(offsetMag),
        .offsetNeg(offsetNeg), .gainInWindow(gainInWindow));
    gacs_far_model gacs_far_model_i (.clk(clk), .resyncReq(resyncReq),
        .calibrationRunning(calibrationRunning), .calOverride(calOverride), .sampleRise(sampleRise),
        .sampleFall(sampleFall), .outputClockResync(outputClockResync));

    // ------------------------------------------------------------
    // Clock, timeout and result reporting
    // ------------------------------------------------------------
    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Note an expected field of the output vector: low bit, width, value
    task automatic ex(input int lsb, input int w, input logic [15:0] val);
        expQ.push_back({8'(lsb), 8'(w), val});
    endtask
    // Monitor takes the oldest note as soon as one is posted
    initial forever begin
        logic [31:0] e;
        wait (expQ.size() != 0);
        e = expQ.pop_front();
        check(16'((outs >> e[31:24]) & ((23'h1 << e[23:16]) - 23'h1)), e[15:0]);
    end
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        wrEn = 1'b1;
        wrAddr = a;
        wrData = d;
        @(posedge clk);
        #1 wrEn = 1'b0;
        // One idle edge so a following write never re-raises the strobe in this time step
        @(posedge clk);
        #1;
    endtask
    // Hold resync, then release and count sampling rises after the aligning fall
    task automatic resync_cycle;
        #1 resyncReq = 1'b1;
        repeat (3) @(posedge clk);
        #1 ex(20, 1, 16'h0001);
        ex(19, 1, ddrEnable ? 16'h0000 : {15'h0, ~es});
        ex(21, 1, ddrEnable ? 16'h0001 : 16'(es));
        resyncReq = 1'b0;
        n = 0;
        fs = 0;
        rl = 0;
        for (int j = 0; j < 100; j++) begin
            @(posedge clk);
            if (sampleRise && fs != 0) n++;
            if (sampleFall && rl != 0) fs = 1;
            // Release is the first rise seen with resync already low
            if (sampleRise && !outputClockResync) rl = 1;
            #1;
            if (!outClockHeld) break;
        end
        check(16'(n), 16'h0004);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        n = $urandom(32'hAABFA5E0);
        repeat (2) @(posedge clk);
        #1 rstn = 1'b1;
        ex(0, 9, 16'h0100);
        ex(19, 4, 16'h0000);
        ex(10, 9, 16'h0000);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            v = (i == 5) ? 9'($urandom) : gTab[i];
            wr(4'h3, {v, 7'($urandom)});
            ex(0, 9, 16'(v));
            ex(9, 1, 16'((v >= 9'h0C0) && (v <= 9'h1C0)));
        end
        wr(4'h5, 16'h0000);
        ex(0, 9, 16'(v));
        wr(4'h2, 16'h007F);
        ex(10, 9, 16'h0000);
        wr(4'h2, 16'h00FF);
        ex(10, 9, 16'h0100);
        $display("test registers done");
        // Every rate, edge value and edge source, asserted at varied phases
        for (int k = 0; k < 8; k++) begin
            {es, extendedMode, ddrEnable} = 3'(k);
            outputEdgeBit = extendedMode ? es : ~es;
            outputEdgeSelectPin = ~outputEdgeBit;
            repeat (3 + k) @(posedge clk);
            resync_cycle();
        end
        $display("test resync done");
        calibrationRunning = 1'b1;
        calOverride = 1'b1;
        repeat (2) @(posedge clk);
        resync_cycle();
        ex(22, 1, 16'h0001);
        $display("test calibration clash done");
        #1 tally_and_finish();
    end
endmodule
`default_nettype wire
